// file: inc/pmpt_map.svh
`ifndef PMPT_MAP_SVH
`define PMPT_MAP_SVH

// Register indexes; the APB byte address is four times the index.
`define PMPT_IDX_CTRL 12'h0cc
`define PMPT_IDX_RELOAD 12'h0cf
`define PMPT_IDX_STATUS 12'h0d0

// Control register bit positions.
`define PMPT_BIT_RUN 0
`define PMPT_BIT_MID 1
`define PMPT_BIT_HIGH 2

// Status register bit positions above the counter byte.
`define PMPT_BIT_ST_PIN 8
`define PMPT_BIT_ST_ARMED 9

// Reset values.
`define PMPT_RST_RELOAD 8'h00
`define PMPT_RST_CTRL 3'h0

// Oscillator cycles per instruction cycle, and the high part of one.
`define PMPT_TC_DIV 4'ha
`define PMPT_TC_HIGH 4'h5

`endif

// file: inc/pmpt_pkg.sv
package pmpt_pkg;

  typedef enum logic [1:0] {
    PMPT_MODE_SQUARE = 2'b00,
    PMPT_MODE_VARDUTY = 2'b01,
    PMPT_MODE_BURST_TC = 2'b10,
    PMPT_MODE_BURST_OSC = 2'b11
  } pmpt_mode_e;

  typedef logic [7:0] pmpt_count_t;

endpackage : pmpt_pkg

// file: hw/pmpt_sync3.sv
`timescale 1ns/1ps
module pmpt_sync3 (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic agree;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change only counts once two stages agree, which filters a metastable sample.
  assign agree = (s2_q == s3_q);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvl_q <= 1'b0;
    end else if (agree) begin
      lvl_q <= s3_q;
    end
  end

  assign o_level = lvl_q;
  assign o_rise = agree & s3_q & ~lvl_q;
  assign o_fall = agree & ~s3_q & lvl_q;

endmodule : pmpt_sync3

// file: hw/pmpt_tc_div.sv
`timescale 1ns/1ps
`include "pmpt_map.svh"
module pmpt_tc_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_osc_rise,
  output logic o_tc_level,
  output logic o_tc_rise,
  output logic o_tc_fall
);

  logic [3:0] cnt_q;
  logic lvl_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
    end else if (i_osc_rise) begin
      if (cnt_q == `PMPT_TC_DIV - 4'h1) begin
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  assign o_tc_rise = i_osc_rise & (cnt_q == `PMPT_TC_DIV - 4'h1);
  assign o_tc_fall = i_osc_rise & (cnt_q == `PMPT_TC_HIGH - 4'h1);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvl_q <= 1'b0;
    end else if (o_tc_rise) begin
      lvl_q <= 1'b1;
    end else if (o_tc_fall) begin
      lvl_q <= 1'b0;
    end
  end

  assign o_tc_level = lvl_q;

endmodule : pmpt_tc_div

// file: hw/pmpt_top.sv
// Functional notes
// - Both select bits high picks oscillator; high only picks instruction clock.
// - Instruction-cycle clock is the oscillator divided by ten.
// - Burst mode passes selected clock pulses to the pin until underflow.
// - Burst underflow clears run, stops counter, holds pin low until restart.
// - Setting run by software copies reload into the down counter.
// - Writing run to zero stops the down counter.
// - Run high with both upper bits low gives a 50% square wave.
// - Square mode counts instruction cycles; each underflow inverts the pin.
// - Square wave runs on until software clears run.
// - High low, middle high selects variable duty; run ignored for selection.
// - In variable duty, general timer underflow sets run, starts counter, drives pin high.
// - Variable duty underflow clears run, pin low until next timer underflow.
// - Reset clears run and both select bits, pin is ordinary port.
// - Reload register sits at index 0cf.
// - Run and select bits sit in the auxiliary control register.
`timescale 1ns/1ps
`include "pmpt_map.svh"
module pmpt_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [13:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_oscillator_input,
  input wire logic i_general_timer_uf,
  output logic o_modulator_out_pin,
  output logic o_modulator_out_oe
);

  logic osc_rise;
  logic osc_fall;
  logic tc_rise;
  logic tc_fall;

  pmpt_sync3 u_osc_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_oscillator_input),
    .o_level(),
    .o_rise(osc_rise),
    .o_fall(osc_fall)
  );

  pmpt_tc_div u_tc_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_osc_rise(osc_rise),
    .o_tc_level(),
    .o_tc_rise(tc_rise),
    .o_tc_fall(tc_fall)
  );

  // Register state.
  logic mod_select_mid_q;
  logic mod_select_high_q;
  logic mod_run_bit_q;
  pmpt_pkg::pmpt_count_t pulse_count_reload_q;
  pmpt_pkg::pmpt_count_t cnt_q;
  logic armed_q;
  logic pin_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // APB decode.
  logic [11:0] idx;
  logic addr_ok;
  logic setup;
  logic wr;
  logic ctrl_wr;
  logic reload_wr;
  logic sw_set;
  logic sw_clr;
  pmpt_pkg::pmpt_mode_e mode;

  assign idx = i_paddr[13:2];
  assign addr_ok = (i_paddr[1:0] == 2'h0) &&
                   ((idx == `PMPT_IDX_CTRL) || (idx == `PMPT_IDX_RELOAD) ||
                    (idx == `PMPT_IDX_STATUS));
  assign setup = i_psel & ~i_penable;
  assign o_pready = 1'b1;
  assign wr = i_psel & i_penable & i_pwrite & o_pready & addr_ok & i_pstrb[0];
  assign ctrl_wr = wr & (idx == `PMPT_IDX_CTRL);
  assign reload_wr = wr & (idx == `PMPT_IDX_RELOAD);
  assign sw_set = ctrl_wr & i_pwdata[`PMPT_BIT_RUN];
  assign sw_clr = ctrl_wr & ~i_pwdata[`PMPT_BIT_RUN];
  assign mode = pmpt_pkg::pmpt_mode_e'({mod_select_high_q, mod_select_mid_q});

  // Read data is captured in the setup cycle so it stands through the access phase.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~addr_ok;
      prdata_q <= 32'h0;
      if (addr_ok && !i_pwrite) begin
        case (idx)
          `PMPT_IDX_CTRL: begin
            prdata_q <= {29'h0, mod_select_high_q, mod_select_mid_q, mod_run_bit_q};
          end
          `PMPT_IDX_RELOAD: begin
            prdata_q <= {24'h0, pulse_count_reload_q};
          end
          `PMPT_IDX_STATUS: begin
            prdata_q <= {22'h0, armed_q, pin_q, cnt_q};
          end
          default: begin
            prdata_q <= 32'h0;
          end
        endcase
      end
    end
  end

  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q & i_psel & i_penable;

  // Mode select bits.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mod_select_mid_q <= 1'b0;
      mod_select_high_q <= 1'b0;
    end else if (ctrl_wr) begin
      mod_select_mid_q <= i_pwdata[`PMPT_BIT_MID];
      mod_select_high_q <= i_pwdata[`PMPT_BIT_HIGH];
    end
  end

  // Software loads n minus one here for n pulses; the byte covers up to 256.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_count_reload_q <= `PMPT_RST_RELOAD;
    end else if (reload_wr) begin
      pulse_count_reload_q <= i_pwdata[7:0];
    end
  end

  // Selected burst clock.
  logic sel_rise;
  logic sel_fall;
  assign sel_rise = (mode == pmpt_pkg::PMPT_MODE_BURST_OSC) ? osc_rise : tc_rise;
  assign sel_fall = (mode == pmpt_pkg::PMPT_MODE_BURST_OSC) ? osc_fall : tc_fall;

  logic burst;
  assign burst = mod_select_high_q;
  logic timer_start;
  assign timer_start = (mode == pmpt_pkg::PMPT_MODE_VARDUTY) & i_general_timer_uf;

  // Counter, run bit and pin. A timer start beats a software clear in the same cycle,
  // and a software set beats a hardware underflow clear, so no start is ever lost.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mod_run_bit_q <= 1'b0;
      cnt_q <= 8'h00;
      armed_q <= 1'b0;
      pin_q <= 1'b0;
    end else if (timer_start) begin
      mod_run_bit_q <= 1'b1;
      cnt_q <= pulse_count_reload_q;
      armed_q <= 1'b0;
      pin_q <= 1'b1;
    end else if (sw_set) begin
      mod_run_bit_q <= 1'b1;
      cnt_q <= pulse_count_reload_q;
      armed_q <= 1'b0;
      pin_q <= 1'b0;
    end else if (sw_clr) begin
      mod_run_bit_q <= 1'b0;
      armed_q <= 1'b0;
      pin_q <= 1'b0;
    end else if (mod_run_bit_q) begin
      case (mode)
        pmpt_pkg::PMPT_MODE_SQUARE: begin
          if (tc_rise) begin
            if (cnt_q == 8'h00) begin
              pin_q <= ~pin_q;
              cnt_q <= pulse_count_reload_q;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
        end
        pmpt_pkg::PMPT_MODE_VARDUTY: begin
          if (tc_rise) begin
            if (cnt_q == 8'h00) begin
              mod_run_bit_q <= 1'b0;
              pin_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
        end
        pmpt_pkg::PMPT_MODE_BURST_TC, pmpt_pkg::PMPT_MODE_BURST_OSC: begin
          // Output starts at a clock rising edge so the first pulse is never a sliver.
          if (sel_rise) begin
            armed_q <= 1'b1;
            pin_q <= 1'b1;
          end else if (sel_fall && armed_q) begin
            pin_q <= 1'b0;
            if (cnt_q == 8'h00) begin
              mod_run_bit_q <= 1'b0;
              armed_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
        end
        default: begin
          pin_q <= 1'b0;
        end
      endcase
    end else begin
      // Stopped: the pin idles low; software times the gap between bursts.
      pin_q <= 1'b0;
    end
  end

  // The pin is taken over while either select bit or the run bit is set.
  assign o_modulator_out_pin = pin_q;
  assign o_modulator_out_oe = burst | mod_select_mid_q | mod_run_bit_q;

  // Checks.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic [3:0] osc_since_tc_q;
  logic tc_seen_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_since_tc_q <= 4'h0;
      tc_seen_q <= 1'b0;
    end else if (tc_rise) begin
      osc_since_tc_q <= 4'h0;
      tc_seen_q <= 1'b1;
    end else if (osc_rise) begin
      osc_since_tc_q <= osc_since_tc_q + 4'h1;
    end
  end

  property p_tc_ratio;
    (tc_rise && tc_seen_q) |-> (osc_since_tc_q == 4'h9);
  endproperty
  a_tc_ratio: assert property (p_tc_ratio) else $error("tc period not ten osc cycles");

  property p_sw_load;
    (sw_set && !timer_start) |=> (mod_run_bit_q && cnt_q == $past(pulse_count_reload_q));
  endproperty
  a_sw_load: assert property (p_sw_load) else $error("run set did not load counter");

  property p_sw_stop;
    (sw_clr && !timer_start) |=> (!mod_run_bit_q && !pin_q);
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("run clear did not stop");

  property p_burst_end;
    (burst && mod_run_bit_q && armed_q && sel_fall && !sel_rise && cnt_q == 8'h00 && !ctrl_wr)
      |=> (!mod_run_bit_q && !pin_q);
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst underflow did not stop");

  property p_burst_idle;
    (burst && !mod_run_bit_q && !ctrl_wr) |=> !pin_q;
  endproperty
  a_burst_idle: assert property (p_burst_idle) else $error("pin not low after burst");

  property p_burst_osc_pass;
    (mode == pmpt_pkg::PMPT_MODE_BURST_OSC && mod_run_bit_q && osc_rise && !ctrl_wr)
      |=> pin_q ##1 (pin_q || $past(osc_fall) || $past(ctrl_wr) || !mod_run_bit_q);
  endproperty
  a_burst_osc_pass: assert property (p_burst_osc_pass) else $error("osc pulse not passed");

  property p_burst_tc_pass;
    (mode == pmpt_pkg::PMPT_MODE_BURST_TC && mod_run_bit_q && tc_rise && !ctrl_wr) |=> pin_q;
  endproperty
  a_burst_tc_pass: assert property (p_burst_tc_pass) else $error("tc pulse not passed");

  property p_sq_toggle;
    (mode == pmpt_pkg::PMPT_MODE_SQUARE && mod_run_bit_q && tc_rise && cnt_q == 8'h00 &&
     !ctrl_wr) |=> (pin_q != $past(pin_q) && cnt_q == $past(pulse_count_reload_q));
  endproperty
  a_sq_toggle: assert property (p_sq_toggle) else $error("square underflow no toggle");

  property p_sq_free;
    (mode == pmpt_pkg::PMPT_MODE_SQUARE && mod_run_bit_q && !ctrl_wr) |=> mod_run_bit_q;
  endproperty
  a_sq_free: assert property (p_sq_free) else $error("square wave stopped by itself");

  property p_var_start;
    timer_start |=> (mod_run_bit_q && pin_q && cnt_q == $past(pulse_count_reload_q));
  endproperty
  a_var_start: assert property (p_var_start) else $error("timer underflow no start");

  property p_var_end;
    (mode == pmpt_pkg::PMPT_MODE_VARDUTY && mod_run_bit_q && tc_rise && cnt_q == 8'h00 &&
     !timer_start && !ctrl_wr) |=> (!mod_run_bit_q && !pin_q);
  endproperty
  a_var_end: assert property (p_var_end) else $error("duty underflow did not end pulse");

  property p_reset_clear;
    @(posedge i_clk) disable iff (1'b0)
      i_rst |=> (!mod_run_bit_q && !mod_select_mid_q && !mod_select_high_q &&
                 !o_modulator_out_oe);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left bits set");

  property p_reload_map;
    reload_wr |=> (pulse_count_reload_q == $past(i_pwdata[7:0]));
  endproperty
  a_reload_map: assert property (p_reload_map) else $error("reload write lost");

  property p_sq_count;
    (mode == pmpt_pkg::PMPT_MODE_SQUARE && mod_run_bit_q && tc_rise && cnt_q != 8'h00 &&
     !ctrl_wr) |=> (cnt_q == $past(cnt_q) - 8'h01 && pin_q == $past(pin_q));
  endproperty
  a_sq_count: assert property (p_sq_count) else $error("square count did not step");

  property p_var_idle;
    (mode == pmpt_pkg::PMPT_MODE_VARDUTY && !mod_run_bit_q && !timer_start && !ctrl_wr)
      |=> !pin_q;
  endproperty
  a_var_idle: assert property (p_var_idle) else $error("pin high between duty pulses");

  property p_strobe_off;
    (i_psel && i_penable && i_pwrite && !i_pstrb[0]) |=> $stable(pulse_count_reload_q);
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("write without strobe landed");

  c_burst_done: cover property (burst && mod_run_bit_q ##1 !mod_run_bit_q);
  c_sq_toggle: cover property (mode == pmpt_pkg::PMPT_MODE_SQUARE && mod_run_bit_q && pin_q);
  c_var_pulse: cover property (timer_start ##[1:1000] !pin_q);
  c_osc_burst: cover property (mode == pmpt_pkg::PMPT_MODE_BURST_OSC && mod_run_bit_q && pin_q);
  c_bus_error: cover property (o_pslverr);

endmodule : pmpt_top

// file: test/pmpt_load_model.sv
`timescale 1ns/1ps
module pmpt_load_model (
  input wire logic i_pin,
  input wire logic i_oe,
  output logic o_osc,
  output int o_pulses
);
  // The oscillator runs free; 40 ns is eight clocks, odd phase avoids clock edges.
  initial begin
    o_osc = 1'b0;
    #1.3;
    forever #20 o_osc = ~o_osc;
  end

  // The emitter only sees pulses while the pin is driven as an output.
  initial o_pulses = 0;
  always @(posedge i_pin) begin
    if (i_oe === 1'b1) begin
      o_pulses++;
    end
  end
endmodule : pmpt_load_model

// file: test/tb_pulse_modulator_pwm_timer.sv
`timescale 1ns/1ps
`include "pmpt_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module tb_pulse_modulator_pwm_timer;
  localparam int TC_CLK = 80;
  localparam logic [13:0] A_CTRL = {`PMPT_IDX_CTRL, 2'b00};
  localparam logic [13:0] A_REL = {`PMPT_IDX_RELOAD, 2'b00};
  localparam logic [13:0] A_STAT = {`PMPT_IDX_STATUS, 2'b00};
  logic clk, rst, psel, penable, pwrite, pready, pslverr, osc, uf, pin, oe, err;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0] pstrb;
  logic [7:0] r, s;
  int miscompares, n_compared, pulses, p0, cyc, t;
  int exp_q[$];

  pmpt_top dut_u (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_oscillator_input(osc), .i_general_timer_uf(uf),
    .o_modulator_out_pin(pin), .o_modulator_out_oe(oe));
  pmpt_load_model load_u (.i_pin(pin), .i_oe(oe), .o_osc(osc), .o_pulses(pulses));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task conclude();
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin miscompares++; conclude(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts settled samples until the pin reaches the level.
  task wait_pin(input logic lvl, input int bound, output int n);
    n = 0;
    while (pin !== lvl) begin
      @(negedge clk);
      n++;
      if (n > bound) begin miscompares++; conclude(); end
    end
  endtask : wait_pin

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; pstrb = 4'hf; uf = 1'b0; seed = 32'd95120;
    miscompares = 0; n_compared = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, A_CTRL, '0);
    `CHK(rd, 32'h0)
    `CHK(oe, 1'b0)
    `CHK(pin, 1'b0)
    r = 8'(rnd());
    apb(1'b1, A_REL, {24'h0, r});
    apb(1'b0, A_REL, '0);
    `CHK(rd, {24'h0, r})
    apb(1'b0, 14'h0004, '0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    pstrb <= 4'he;
    apb(1'b1, A_REL, {24'h0, ~r});
    pstrb <= 4'hf;
    apb(1'b0, A_REL, '0);
    `CHK(rd, {24'h0, r})
    for (int m = 0; m < 2; m++) begin
      r = 8'(rnd() % (m ? 8 : 3));
      apb(1'b1, A_REL, {24'h0, r}); // Reload n minus one.
      exp_q.push_back(r + 1);
      exp_q.push_back(r + 1);
      for (int k = 0; k < 2; k++) begin
        p0 = pulses;
        apb(1'b1, A_CTRL, m ? 32'h7 : 32'h5);
        t = 0;
        do begin apb(1'b0, A_CTRL, '0); t++; end while (rd[0] !== 1'b0 && t < 400);
        if (rd[0] !== 1'b0) begin miscompares++; conclude(); end
        `CHK(rd[2:0], m ? 3'h6 : 3'h4)
        `CHK(pulses - p0, exp_q.pop_front())
        `CHK(pin, 1'b0)
        repeat (20) @(posedge clk); // Gap between bursts timed here.
      end
    end
    apb(1'b1, A_REL, 32'hc8);
    apb(1'b1, A_CTRL, 32'h5);
    repeat (300) @(posedge clk);
    apb(1'b1, A_CTRL, 32'h4);
    apb(1'b0, A_STAT, '0);
    s = rd[7:0];
    p0 = pulses;
    repeat (300) @(posedge clk);
    apb(1'b0, A_STAT, '0);
    `CHK(rd[7:0], s)
    `CHK(pulses, p0)
    r = 8'(rnd() % 4);
    apb(1'b1, A_REL, {24'h0, r});
    apb(1'b1, A_CTRL, 32'h1);
    wait_pin(1'b1, 600, cyc);
    `CHK(oe, 1'b1)
    for (int k = 0; k < 3; k++) begin
      wait_pin(~pin, 400, cyc);
      `CHK(cyc, (r + 1) * TC_CLK)
    end
    apb(1'b1, A_CTRL, 32'h0);
    @(negedge clk);
    `CHK(oe, 1'b0)
    r = 8'(rnd() % 3) + 8'h1;
    apb(1'b1, A_REL, {24'h0, r});
    apb(1'b1, A_CTRL, 32'h2);
    for (int k = 0; k < 2; k++) begin
      // Timer in auto-reload toggle mode yields one pulse per underflow.
      @(posedge clk);
      uf <= 1'b1;
      @(posedge clk);
      uf <= 1'b0;
      wait_pin(1'b1, 4, cyc);
      wait_pin(1'b0, (r + 1) * TC_CLK + 4, cyc);
      `CHK(cyc > r * TC_CLK, 1'b1)
      `CHK(cyc <= (r + 1) * TC_CLK, 1'b1)
      apb(1'b0, A_CTRL, '0);
      `CHK(rd[2:0], 3'h2)
      repeat (50) @(posedge clk);
    end
    // A reset in mid-run must drop every control bit and give the pin back.
    apb(1'b1, A_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, A_CTRL, '0);
    `CHK(rd, 32'h0)
    `CHK(oe, 1'b0)
    `CHK(pin, 1'b0)
    apb(1'b0, A_REL, '0);
    `CHK(rd[7:0], `PMPT_RST_RELOAD)
    conclude();
  end
endmodule : tb_pulse_modulator_pwm_timer
